// File: src/sere_map.svh
/*
 Constants of the serial EEPROM read engine: command byte layout,
 bus timing and buffer sizes. Included by bare name; no code here.
*/
`ifndef SERE_MAP_SVH
`define SERE_MAP_SVH

// Device type code in the upper nibble of every command byte.
`define SERE_DEV_CODE 4'hA
`define SERE_DEV_MSB 7
`define SERE_DEV_LSB 4
// Position of the read/write select bit in a command byte.
`define SERE_RW_BIT 0
// Lowest command bit carrying upper address bits.
`define SERE_HI_LSB 1
`define SERE_BITS_PER_BYTE 4'h8
`define SERE_LAST_TX_BIT 4'h7
`define SERE_ADDR_W_DEFAULT 11
`define SERE_FIFO_DEPTH 4
`define SERE_CLK_MHZ 40
`define SERE_SPIKE_MIN_NS 50
`define SERE_SPIKE_MAX_NS 100
// Least time rounds up to whole clock cycles.
`define SERE_SPIKE_CYC ((`SERE_SPIKE_MIN_NS * `SERE_CLK_MHZ + 999) / 1000)
`define SERE_IDLE_BYTE 8'hFF

`endif

// File: src/sere_pkg.sv
/*
 Types shared by the serial EEPROM read engine.
 Assumes nothing of its surroundings.
*/
`default_nettype none

package sere_pkg;

	typedef enum logic [2:0] {
		SERE_IDLE = 3'h0,
		SERE_CMD = 3'h1,
		SERE_CMD_ACK = 3'h3,
		SERE_TX = 3'h2,
		SERE_TX_ACK = 3'h6,
		SERE_ADDR = 3'h7,
		SERE_ADDR_ACK = 3'h5,
		SERE_WAIT = 3'h4
	} sere_state_type;

endpackage

`default_nettype wire

// File: src/sere_fifo_if.sv
/*
 Channel between the read engine and its prefetch FIFO.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface sere_fifo_if #(
	parameter int W = 8
);
	logic wr_valid;
	logic wr_ready;
	logic [W-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [W-1:0] rd_data;
	logic flush;

	modport fifo (
		input wr_valid,
		input wr_data,
		input rd_ready,
		input flush,
		output wr_ready,
		output rd_valid,
		output rd_data
	);

	modport user (
		output wr_valid,
		output wr_data,
		output rd_ready,
		output flush,
		input wr_ready,
		input rd_valid,
		input rd_data
	);
endinterface // sere_fifo_if

`default_nettype wire

// File: src/sere_fifo.sv
/*
 Small synchronous FIFO with valid/ready on both sides and a flush.
 Assumes DEPTH is a power of two and a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module sere_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	sere_fifo_if.fifo port
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic full;
	logic empty;
	logic do_wr;
	logic do_rd;

	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign port.wr_ready = !full;
	assign port.rd_valid = !empty;
	assign port.rd_data = mem_reg[rd_ptr_reg[AW-1:0]];
	assign do_wr = port.wr_valid && !full;
	assign do_rd = port.rd_ready && !empty;

	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= port.wr_data;
		end
	end

	// Flush wins over a push or pop in the same cycle.
	always_ff @(posedge clk) begin
		if (!rst_n || port.flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule // sere_fifo

`default_nettype wire

// File: src/sere_read_engine.sv
/*
 Read engine of a two-wire serial EEPROM target: command decode,
 address setting, current-address and sequential reads, prefetch FIFO.
 Assumes a byte-wide memory outside with one-cycle registered read,
 and an open-drain SDA resolved by the surroundings.
*/
// What this block does
// R1 - After acknowledging a read command it shifts one stored byte out over the next eight SCL pulses and advances the address counter.
// R2 - It acknowledges a matching read command byte by pulling SDA low during the ninth clock.
// R3 - A read may start with START and the read command byte alone, without any address phase.
// R4 - A current-address read takes its data from the address the counter already holds.
// R5 - The master asks for further bytes by pulling SDA low on the ninth clock of each data byte.
// R6 - When the master acknowledges a data byte the next byte follows with no new command.
// R7 - The address counter grows by exactly one for each byte transmitted.
// R8 - Past the highest location the counter wraps to address zero and reading goes on.
// R9 - The master ends a read by leaving SDA released on the last ninth clock and then sending STOP.
// R10 - Pulses on SDA and SCL shorter than the spike window of 50 to 100 ns are ignored.
// R11 - Bit zero of a command byte selects read when one and write or address setting when zero.
// R12 - Every byte takes nine SCL pulses: eight data bits MSB first and one acknowledge bit.
// R13 - A STOP after a data byte returns the engine to standby.
// R14 - A random read loads the counter by a write command and address byte, then a repeated START and read command.
// R15 - Without an acknowledge from the master SDA is released and the engine stays passive until the next START.
// R16 - The counter is ten bits wide for 1024 bytes and eleven bits for 2048 bytes.
`timescale 1ns/1ps
`default_nettype none
`include "sere_map.svh"

module sere_read_engine #(
	parameter int ADDR_W = `SERE_ADDR_W_DEFAULT,
	parameter int FIFO_DEPTH = `SERE_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic mem_rd,
	output logic [ADDR_W-1:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	output logic busy
);
	localparam int HI_W = ADDR_W - 8;
	localparam logic [2:0] FILT_CYC = 3'(`SERE_SPIKE_CYC);

	sere_pkg::sere_state_type state_reg;
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic [1:0] raw;
	logic [1:0] filt_reg;
	logic [2:0] filt_cnt_reg [2];
	logic scl_d_reg;
	logic sda_d_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [3:0] bit_cnt_reg;
	logic [7:0] rx_shift_reg;
	logic [7:0] tx_shift_reg;
	logic is_read_reg;
	logic ack_seen_reg;
	logic [HI_W-1:0] hi_reg;
	logic [ADDR_W-1:0] addr_cnt_reg;
	logic [ADDR_W-1:0] fetch_addr_reg;
	logic [ADDR_W-1:0] addr_load_val;
	logic rd_pend_reg;
	logic rsp_valid_reg;
	logic rx_done;
	logic cmd_match;
	logic load_addr;
	logic pop_byte;
	logic flush;
	logic [7:0] next_byte;

	sere_fifo_if #(.W(8)) fifo_ch ();

	sere_fifo #(
		.W(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(core_clk),
		.rst_n(rst_n),
		.port(fifo_ch.fifo)
	);

	// Both bus lines are asynchronous to core_clk.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i};
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
		end
	end

	assign raw = {scl_sync_reg[1], sda_sync_reg[1]};

	// A level is accepted only after it differs for FILT_CYC+1 samples,
	// so 50 ns pulses die and anything from about 75 ns on passes.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			filt_reg <= 2'h3;
			filt_cnt_reg[0] <= 3'h0;
			filt_cnt_reg[1] <= 3'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (raw[i] == filt_reg[i]) begin
					filt_cnt_reg[i] <= 3'h0; // R10
				end else if (filt_cnt_reg[i] == FILT_CYC) begin
					filt_reg[i] <= raw[i]; // R10
					filt_cnt_reg[i] <= 3'h0;
				end else begin
					filt_cnt_reg[i] <= filt_cnt_reg[i] + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= filt_reg[1];
			sda_d_reg <= filt_reg[0];
		end
	end

	assign scl_rise = filt_reg[1] && !scl_d_reg;
	assign scl_fall = !filt_reg[1] && scl_d_reg;
	assign start_cond = filt_reg[1] && scl_d_reg && sda_d_reg && !filt_reg[0];
	assign stop_cond = filt_reg[1] && scl_d_reg && !sda_d_reg && filt_reg[0];

	assign rx_done = scl_fall && (bit_cnt_reg == `SERE_BITS_PER_BYTE) &&
		(state_reg == sere_pkg::SERE_CMD || state_reg == sere_pkg::SERE_ADDR);
	assign cmd_match =
		(rx_shift_reg[`SERE_DEV_MSB:`SERE_DEV_LSB] == `SERE_DEV_CODE);
	assign load_addr = rx_done && (state_reg == sere_pkg::SERE_ADDR) &&
		!start_cond && !stop_cond; // R14
	assign pop_byte = scl_fall && !start_cond && !stop_cond &&
		((state_reg == sere_pkg::SERE_CMD_ACK && is_read_reg) ||
		(state_reg == sere_pkg::SERE_TX_ACK && ack_seen_reg)); // R6
	assign flush = start_cond || load_addr;
	assign addr_load_val = {hi_reg, rx_shift_reg};
	// An empty buffer sends all ones, which looks like a released line.
	assign next_byte = fifo_ch.rd_valid ? fifo_ch.rd_data : `SERE_IDLE_BYTE;

	assign fifo_ch.rd_ready = pop_byte;
	assign fifo_ch.flush = flush;
	assign fifo_ch.wr_valid = rsp_valid_reg && !flush;
	assign fifo_ch.wr_data = mem_rdata;

	// Bus protocol. STOP outranks START, which outranks any bit event.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg <= sere_pkg::SERE_IDLE;
			bit_cnt_reg <= 4'h0;
			rx_shift_reg <= 8'h00;
			tx_shift_reg <= 8'hFF;
			is_read_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
			sda_oe <= 1'b0;
		end else if (stop_cond) begin
			state_reg <= sere_pkg::SERE_IDLE; // R13
			sda_oe <= 1'b0;
		end else if (start_cond) begin
			state_reg <= sere_pkg::SERE_CMD; // R3
			bit_cnt_reg <= 4'h0;
			sda_oe <= 1'b0;
		end else begin
			unique case (state_reg)
				sere_pkg::SERE_IDLE, sere_pkg::SERE_WAIT: begin
				end
				sere_pkg::SERE_CMD, sere_pkg::SERE_ADDR: begin
					if (scl_rise && bit_cnt_reg != `SERE_BITS_PER_BYTE) begin
						rx_shift_reg <= {rx_shift_reg[6:0], filt_reg[0]}; // R12
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (rx_done) begin
						bit_cnt_reg <= 4'h0;
						if (state_reg == sere_pkg::SERE_ADDR) begin
							sda_oe <= 1'b1;
							state_reg <= sere_pkg::SERE_ADDR_ACK;
						end else if (cmd_match) begin
							sda_oe <= 1'b1; // R2
							is_read_reg <= rx_shift_reg[`SERE_RW_BIT]; // R11
							state_reg <= sere_pkg::SERE_CMD_ACK;
						end else begin
							state_reg <= sere_pkg::SERE_WAIT;
						end
					end
				end
				sere_pkg::SERE_CMD_ACK: begin
					if (scl_fall) begin
						if (is_read_reg) begin
							tx_shift_reg <= next_byte; // R4
							sda_oe <= !next_byte[7]; // R1
							state_reg <= sere_pkg::SERE_TX;
						end else begin
							sda_oe <= 1'b0;
							state_reg <= sere_pkg::SERE_ADDR;
						end
					end
				end
				sere_pkg::SERE_ADDR_ACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						state_reg <= sere_pkg::SERE_WAIT;
					end
				end
				sere_pkg::SERE_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == `SERE_LAST_TX_BIT) begin
							sda_oe <= 1'b0; // R12
							bit_cnt_reg <= 4'h0;
							state_reg <= sere_pkg::SERE_TX_ACK;
						end else begin
							sda_oe <= !tx_shift_reg[6]; // R1
							tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				sere_pkg::SERE_TX_ACK: begin
					if (scl_rise) begin
						ack_seen_reg <= !filt_reg[0]; // R5
					end else if (scl_fall) begin
						if (ack_seen_reg) begin
							tx_shift_reg <= next_byte; // R6
							sda_oe <= !next_byte[7];
							state_reg <= sere_pkg::SERE_TX;
						end else begin
							state_reg <= sere_pkg::SERE_WAIT; // R15
						end
					end
				end
			endcase
		end
	end

	// Address counter; its width sets the wrap point.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			addr_cnt_reg <= '0;
			hi_reg <= '0;
		end else begin
			if (rx_done && state_reg == sere_pkg::SERE_CMD && cmd_match &&
				!rx_shift_reg[`SERE_RW_BIT] && !start_cond && !stop_cond) begin
				hi_reg <= rx_shift_reg[HI_W:`SERE_HI_LSB]; // R16
			end
			if (load_addr) begin
				addr_cnt_reg <= addr_load_val; // R14
			end else if (pop_byte) begin
				addr_cnt_reg <= addr_cnt_reg + 1'b1; // R7 R8
			end
		end
	end

	// Prefetch runs ahead of the counter. Any START or address load
	// discards it, so a read always resumes at the counter.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fetch_addr_reg <= '0;
			mem_addr <= '0;
			mem_rd <= 1'b0;
			rd_pend_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
		end else if (flush) begin
			fetch_addr_reg <= load_addr ? addr_load_val : addr_cnt_reg; // R4
			mem_rd <= 1'b0;
			rd_pend_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
		end else begin
			rsp_valid_reg <= mem_rd;
			mem_rd <= 1'b0;
			if (rsp_valid_reg) begin
				rd_pend_reg <= 1'b0;
			end else if (!rd_pend_reg && fifo_ch.wr_ready) begin
				mem_addr <= fetch_addr_reg;
				mem_rd <= 1'b1;
				rd_pend_reg <= 1'b1;
				fetch_addr_reg <= fetch_addr_reg + 1'b1; // R8
			end
		end
	end

	// The line is only ever pulled low; the driven level stays zero.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sda_o <= 1'b0;
			busy <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			busy <= (state_reg != sere_pkg::SERE_IDLE);
		end
	end
endmodule // sere_read_engine

`default_nettype wire

// File: testbench/sere_bus_master.sv
/*
 Behavioural two-wire bus master that issues read commands.
 Assumes SDA is an open-drain wire with a pull-up, resolved by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module sere_bus_master (
	input wire logic core_clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_pull
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic wait_c(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// SCL stays low 300 ns so that the target's filtered answer settles.
	task automatic bitx(input logic b, output logic r);
		sda_pull <= ~b;
		wait_c(8);
		scl <= 1'b1;
		wait_c(4);
		r = sda_line;
		wait_c(4);
		scl <= 1'b0;
		wait_c(4);
	endtask

	task automatic start();
		sda_pull <= 1'b0;
		wait_c(4);
		scl <= 1'b1;
		wait_c(8);
		sda_pull <= 1'b1;
		wait_c(8);
		scl <= 1'b0;
		wait_c(4);
	endtask

	task automatic stop();
		sda_pull <= 1'b1;
		wait_c(4);
		scl <= 1'b1;
		wait_c(8);
		sda_pull <= 1'b0;
		wait_c(8);
	endtask

	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(ack_in, ack_out);
	endtask

	task automatic spike(input logic on_scl);
		if (on_scl) begin
			scl <= 1'b0;
		end else begin
			sda_pull <= 1'b1;
		end
		wait_c(2);
		scl <= 1'b1;
		sda_pull <= 1'b0;
		wait_c(20);
	endtask
endmodule // sere_bus_master

`default_nettype wire

// File: testbench/sere_read_engine_assertions.sv
/*
 Pin-level checker of the read engine, bound to its top module.
 Assumes only the top module's ports are visible.
*/
`timescale 1ns/1ps
`default_nettype none

module sere_read_engine_checker #(
	parameter int ADDR_W = 11
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic mem_rd,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	input wire logic busy
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sda_o_zero_a: assert property (sda_o == 1'b0)
		else $error("sda_o driven high");
	mem_rd_pulse_a: assert property (mem_rd |=> !mem_rd)
		else $error("memory read not a single pulse");
	reset_quiet_a: assert property (disable iff (1'b0)
		!rst_n |=> !sda_oe && !busy && !mem_rd && mem_addr == '0)
		else $error("outputs not quiet in reset");
	idle_passive_a: assert property (!busy |-> !sda_oe)
		else $error("sda driven while idle");
	oe_scl_low_a: assert property ($changed(sda_oe) |->
		!scl_i && $past(scl_i, 3) == 1'b0)
		else $error("sda changed outside scl low");
	start_busy_a: assert property ((scl_i && $fell(sda_i)) ##1
		(scl_i && !sda_i)[*4] |-> ##[1:6] busy)
		else $error("start not taken");
	stop_idle_a: assert property ((scl_i && $rose(sda_i)) ##1
		(scl_i && sda_i)[*4] |-> ##[1:6] !busy)
		else $error("stop did not reach standby");
	spike_ignored_a: assert property ((!busy && scl_i && $fell(sda_i))
		##1 !sda_i ##1 sda_i[*3] |-> !busy[*4])
		else $error("short sda pulse taken as start");

	cover property ($rose(sda_oe));
	cover property (mem_rd);
	cover property ($fell(busy));
endmodule // sere_read_engine_checker

bind sere_read_engine sere_read_engine_checker #(.ADDR_W(ADDR_W)) i_chk (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.sda_o(sda_o),
	.sda_oe(sda_oe),
	.mem_rd(mem_rd),
	.mem_addr(mem_addr),
	.mem_rdata(mem_rdata),
	.busy(busy)
);

`default_nettype wire

// File: testbench/test_serial_eeprom_read_engine.sv
/*
 Bench of the read engine with a bus master model and a registered memory.
 Assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
`default_nettype none

module test_serial_eeprom_read_engine;
	logic core_clk;
	logic rst_n;
	logic scl;
	logic sda_pull;
	logic sda_line;
	logic sda_o;
	logic sda_oe;
	logic mem_rd;
	logic [10:0] mem_addr;
	logic [7:0] mem_rdata;
	logic busy;
	int n_fail;
	int n_tests;
	int cyc = 0;

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// A released SDA reads high through the pull-up.
	assign sda_line = ~(sda_oe | sda_pull);

	sere_bus_master i_m (
		.core_clk(core_clk),
		.sda_line(sda_line),
		.scl(scl),
		.sda_pull(sda_pull)
	);

	sere_read_engine #(.ADDR_W(11), .FIFO_DEPTH(4)) i_dut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.scl_i(scl),
		.sda_i(sda_line),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.mem_rd(mem_rd),
		.mem_addr(mem_addr),
		.mem_rdata(mem_rdata),
		.busy(busy)
	);

	function automatic logic [7:0] exp_byte(input logic [10:0] a);
		return a[7:0] ^ {a[10:8], 5'h0B};
	endfunction

	// Data is valid only in the cycle after a read, so late sampling fails.
	always @(posedge core_clk) begin
		mem_rdata <= mem_rd ? exp_byte(mem_addr) : ~mem_rdata;
	end

	task automatic give_verdict();
		if (n_fail == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic chk(input string what, input logic [10:0] exp,
		input logic [10:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask

	task automatic rd(input logic [7:0] cmd, input logic [10:0] ad,
		input int n, input logic good);
		logic [7:0] q;
		logic a;
		i_m.start();
		i_m.xfer(cmd, 1'b1, q, a);
		chk("command ack", good ? 11'h000 : 11'h001, 11'(a));
		for (int i = 0; i < n; i++) begin
			i_m.xfer(8'hFF, i == n - 1, q, a);
			chk("data", good ? 11'(exp_byte(ad)) : 11'h0FF, 11'(q));
			ad++;
		end
		repeat (8) @(posedge core_clk);
		chk("sda released", 11'h000, 11'(sda_oe));
		i_m.stop();
		repeat (4) @(posedge core_clk);
		chk("standby", 11'h000, 11'(busy));
	endtask

	task automatic t_random_read();
		logic [7:0] q;
		logic a;
		i_m.start();
		i_m.xfer(8'hAE, 1'b1, q, a);
		chk("write ack", 11'h000, 11'(a));
		i_m.xfer(8'hFE, 1'b1, q, a);
		chk("address ack", 11'h000, 11'(a));
		rd(8'hA1, 11'h7FE, 3, 1'b1);
	endtask

	task automatic t_current_read();
		rd(8'hA7, 11'h001, 2, 1'b1);
	endtask

	task automatic t_refused();
		rd(8'hB1, 11'h000, 1, 1'b0);
	endtask

	task automatic t_spike();
		i_m.spike(1'b0);
		i_m.spike(1'b1);
		chk("busy after spikes", 11'h000, 11'(busy));
		rd(8'hA1, 11'h003, 1, 1'b1);
	endtask

	initial begin
		n_fail = 0;
		n_tests = 0;
		rst_n = 1'b0;
		mem_rdata = 8'h00;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (12) @(posedge core_clk);
		t_random_read();
		t_current_read();
		t_refused();
		t_spike();
		give_verdict();
	end
endmodule // test_serial_eeprom_read_engine

`default_nettype wire
